//--- hdl/cw_lo_pkg.sv
// Constants, register map and helper functions for the CW LO phase logic.
package cw_lo_pkg;
    localparam int NUM_CHANNELS = 8;
    localparam int ADDR_BITS = 13;
    localparam int INSTR_BITS = 16;
    localparam int FRAME_BITS = 24;
    localparam int READ_FLAG_BIT = 23;
    localparam int ADDR_LSB = 8;
    localparam logic [4:0] INSTR_LAST_CNT = 5'h0F;
    localparam logic [4:0] FRAME_LAST_CNT = 5'h17;
    localparam logic [ADDR_BITS-1:0] ADDR_CHANNEL_SELECT = 13'h0005;
    localparam logic [ADDR_BITS-1:0] ADDR_CW_CHANNEL_PHASE_CONTROL = 13'h002D;
    localparam logic [7:0] CHANNEL_SELECT_RESET = 8'hFF;
    localparam logic [3:0] PHASE_CODE_RESET = 4'h0;
    localparam logic CW_ENABLE_RESET = 1'b0;
    localparam int CODE_MSB = 3;
    localparam int CODE_LSB = 0;
    localparam int CW_ENABLE_BIT = 4;
    localparam int COARSE_MSB = 3;
    localparam int COARSE_LSB = 2;
    localparam int FINE_MSB = 1;
    localparam int FINE_LSB = 0;
    localparam logic [1:0] PHASE_START = 2'h0;
    localparam logic [1:0] PHASE_STEP = 2'h1;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    typedef logic [1:0] quarter_t;

    // In-phase LO is high in quarters 0 and 1 of the divided cycle.
    function automatic logic quarter_to_i(input quarter_t q);
        return (q == 2'h0) || (q == 2'h1);
    endfunction

    // Quadrature LO is high in quarters 1 and 2, one 4x period behind I.
    function automatic logic quarter_to_q(input quarter_t q);
        return (q == 2'h1) || (q == 2'h2);
    endfunction
endpackage

//--- hdl/lo_phase_if.sv
// Shared divider state handed from the LO divider to every channel rotator.
`timescale 1ns/1ps
interface lo_phase_if;
    logic [1:0] phase;
    logic held;
    logic apply;
    modport src (output phase, output held, output apply);
    modport dst (input phase, input held, input apply);
endinterface

//--- hdl/lo_channel_rotator.sv
// One channel's quadrature LO rotation and CW enable output stage.
`timescale 1ns/1ps
module lo_channel_rotator
    import cw_lo_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    lo_phase_if.dst lo,
    input wire logic [3:0] i_code,
    input wire logic i_enable,
    output logic o_lo_i,
    output logic o_lo_q,
    output logic [1:0] o_fine_sel,
    output logic o_enable
);
    logic [3:0] code_r;
    logic [1:0] shifted_quarter;
    logic lo_i_nxt;
    logic lo_q_nxt;
    localparam logic [2:0] STEADY_FULL = 3'h7;
    logic [2:0] steady_r;
    logic code_moves;

    // A larger code adds quarters, so this channel reaches each edge sooner.
    assign shifted_quarter = lo.phase + code_r[COARSE_MSB:COARSE_LSB]; // R4
    assign lo_i_nxt = quarter_to_i(shifted_quarter); // R6
    assign lo_q_nxt = quarter_to_q(shifted_quarter); // R6
    assign code_moves = lo.held || (lo.apply && (i_code != code_r));

    // A rotation change legally reshapes one LO period, so the duty check
    // only looks at windows in which code and divider ran undisturbed.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            steady_r <= 3'h0;
        end else if (code_moves) begin
            steady_r <= 3'h0;
        end else if (steady_r != STEADY_FULL) begin
            steady_r <= steady_r + 3'h1;
        end
    end

    // Codes change only at the cycle boundary or while the sync reset holds the divider, so no runt pulse is cut.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            code_r <= PHASE_CODE_RESET;
        end else if (lo.apply) begin
            code_r <= i_code; // R16
        end
    end

    // Final flops retimed straight on the 4x clock keep divider jitter out.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_lo_i <= 1'b0;
            o_lo_q <= 1'b0;
            o_fine_sel <= 2'h0;
            o_enable <= CW_ENABLE_RESET;
        end else begin
            o_lo_i <= lo_i_nxt; // R9
            o_lo_q <= lo_q_nxt; // R9
            o_fine_sel <= code_r[FINE_MSB:FINE_LSB]; // R2
            o_enable <= i_enable; // R14
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    chk_i_duty_half: assert property ( // R8
        ((steady_r == STEADY_FULL) && $fell(o_lo_i)) |->
            ($past(o_lo_i) && $past(o_lo_i, 2) && !$past(o_lo_i, 3)))
        else $error("I LO duty cycle is not two high and two low.");
    chk_q_follows_i: assert property ( // R6
        (!lo.held && !$past(lo.held) && !$past(lo.apply) && !lo.apply)
            |=> (o_lo_q == $past(o_lo_i)))
        else $error("Q LO is not one 4x period behind I LO.");
    chk_rotation_map: assert property ( // R3
        1'b1 |=> (o_lo_i == quarter_to_i($past(lo.phase)
            + $past(code_r[COARSE_MSB:COARSE_LSB]))))
        else $error("I LO does not follow the coarse phase code.");
    chk_code_boundary: assert property ( // R16
        !lo.apply |=> $stable(code_r))
        else $error("Applied phase code changed off the cycle boundary.");
endmodule

//--- hdl/cw_quadrature_lo_phase_select.sv
// Top of the CW LO logic: divider, serial register port, eight rotators.
`timescale 1ns/1ps
// Functional notes
// [R1] Each channel keeps its own independent rotation.
// [R2] Sixteen rotation states, 22.5 degree steps.
// [R3] Code bits 3:0 select code times 22.5.
// [R4] One code step higher leads by 22.5.
// [R5] Equal codes give equal output phase.
// [R6] Same rotation on I and Q outputs.
// [R7] Quadrature LO from divide-by-four of 4x clock.
// [R8] Both LO outputs exactly fifty percent duty.
// [R9] Final LO flops clocked by 4x clock.
// [R10] Reset pin forces divider into known state.
// [R11] Array controller shares one reset pulse.
// [R12] Reset pin active high, held 20 ns.
// [R13] Divider restarts on first edge after release; the code, behind the two sync flops, first advances it on the third edge.
// [R14] Control bit 4 enables channel CW path.
// [R15] Divider static while reset pin held.
// [R16] New code applied on clock edge, glitch-free.
module cw_quadrature_lo_phase_select
    import cw_lo_pkg::*;
#(
    parameter int CHANNELS = NUM_CHANNELS
)(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_lo_sync_reset,
    input wire logic i_spi_csn,
    input wire logic i_spi_sclk,
    input wire logic i_spi_sdio,
    output logic o_spi_sdio,
    output logic o_spi_sdio_oe,
    output logic [CHANNELS-1:0] o_lo_i,
    output logic [CHANNELS-1:0] o_lo_q,
    output logic [2*CHANNELS-1:0] o_fine_sel,
    output logic [CHANNELS-1:0] o_cw_enable
);
    lo_phase_if lo ();

    logic sync_reset_s1_r;
    logic sync_reset_s2_r;
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    logic csn_s1_r;
    logic csn_s2_r;
    logic sclk_s1_r;
    logic sclk_s2_r;
    logic sclk_s3_r;
    logic sdio_s1_r;
    logic sdio_s2_r;
    logic sclk_rise;
    logic sclk_fall;
    logic [4:0] bit_cnt_r;
    logic [FRAME_BITS-2:0] shift_r;
    logic [FRAME_BITS-1:0] frame_word;
    logic [ADDR_BITS-1:0] wr_addr;
    logic [ADDR_BITS-1:0] rd_addr;
    logic wr_strobe;
    logic rd_start;
    logic [7:0] tx_r;
    logic [7:0] rd_data;
    logic [7:0] ctrl_rd;
    logic [7:0] chan_sel_r;
    logic [3:0] code_r [CHANNELS];
    logic [CHANNELS-1:0] cw_en_r;
    logic [$clog2(CHANNELS)-1:0] first_sel;

    // Lowest selected channel answers a control register read.
    function automatic logic [$clog2(CHANNELS)-1:0] lowest_set(
        input logic [7:0] sel);
        logic [$clog2(CHANNELS)-1:0] idx;
        idx = '0;
        for (int k = CHANNELS - 1; k >= 0; k--) begin
            if (sel[k]) begin
                idx = k[$clog2(CHANNELS)-1:0];
            end
        end
        return idx;
    endfunction

    // The sync pin passes two flops; every device sees the same fixed
    // latency, so arrays driven by one pulse stay aligned.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            sync_reset_s1_r <= 1'b0;
            sync_reset_s2_r <= 1'b0;
        end else begin
            sync_reset_s1_r <= i_lo_sync_reset;
            sync_reset_s2_r <= sync_reset_s1_r;
        end
    end

    assign phase_nxt = sync_reset_s2_r ? PHASE_START : // R10 R15
        phase_r + PHASE_STEP; // R7 R13

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            phase_r <= PHASE_START;
        end else begin
            phase_r <= phase_nxt; // R7
        end
    end

    // All channels share this one divider, which keeps equal codes equal.
    assign lo.phase = phase_r; // R5
    assign lo.held = sync_reset_s2_r;
    assign lo.apply = sync_reset_s2_r || (phase_r == PHASE_LAST); // R16

    // Serial port lines come from another domain and are synchronised.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            csn_s1_r <= 1'b1;
            csn_s2_r <= 1'b1;
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            sdio_s1_r <= 1'b0;
            sdio_s2_r <= 1'b0;
        end else begin
            csn_s1_r <= i_spi_csn;
            csn_s2_r <= csn_s1_r;
            sclk_s1_r <= i_spi_sclk;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            sdio_s1_r <= i_spi_sdio;
            sdio_s2_r <= sdio_s1_r;
        end
    end

    assign sclk_rise = !csn_s2_r && sclk_s2_r && !sclk_s3_r;
    assign sclk_fall = !csn_s2_r && !sclk_s2_r && sclk_s3_r;
    assign frame_word = {shift_r, sdio_s2_r};
    assign wr_addr = frame_word[ADDR_LSB+ADDR_BITS-1:ADDR_LSB];
    assign rd_addr = frame_word[ADDR_BITS-1:0];
    assign wr_strobe = sclk_rise && (bit_cnt_r == FRAME_LAST_CNT) &&
        !frame_word[READ_FLAG_BIT];
    assign rd_start = sclk_rise && (bit_cnt_r == INSTR_LAST_CNT) &&
        frame_word[INSTR_BITS-1];
    assign first_sel = lowest_set(chan_sel_r);
    assign ctrl_rd = (chan_sel_r == 8'h00) ? 8'h00 :
        {3'h0, cw_en_r[first_sel], code_r[first_sel]};
    assign rd_data = (rd_addr == ADDR_CHANNEL_SELECT) ? chan_sel_r :
        (rd_addr == ADDR_CW_CHANNEL_PHASE_CONTROL) ? ctrl_rd : 8'h00;

    always_ff @(posedge i_clock) begin
        if (!i_resetn || csn_s2_r) begin
            bit_cnt_r <= 5'h00;
            shift_r <= '0;
        end else if (sclk_rise) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            shift_r <= frame_word[FRAME_BITS-2:0];
        end
    end

    // Read data is presented on falling clocks, ready for the next rise.
    always_ff @(posedge i_clock) begin
        if (!i_resetn || csn_s2_r) begin
            tx_r <= 8'h00;
            o_spi_sdio <= 1'b0;
            o_spi_sdio_oe <= 1'b0;
        end else if (rd_start) begin
            tx_r <= rd_data;
            o_spi_sdio_oe <= 1'b1;
        end else if (sclk_fall && o_spi_sdio_oe) begin
            o_spi_sdio <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    // One write of the control register reaches every selected channel.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            chan_sel_r <= CHANNEL_SELECT_RESET;
            cw_en_r <= '0;
            for (int c = 0; c < CHANNELS; c++) begin
                code_r[c] <= PHASE_CODE_RESET;
            end
        end else if (wr_strobe) begin
            if (wr_addr == ADDR_CHANNEL_SELECT) begin
                chan_sel_r <= frame_word[7:0];
            end
            for (int c = 0; c < CHANNELS; c++) begin
                if (wr_addr == ADDR_CW_CHANNEL_PHASE_CONTROL &&
                        chan_sel_r[c]) begin
                    code_r[c] <= frame_word[CODE_MSB:CODE_LSB]; // R1 R3
                    cw_en_r[c] <= frame_word[CW_ENABLE_BIT]; // R14
                end
            end
        end
    end

    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        lo_channel_rotator u_rot (
            .i_clock(i_clock),
            .i_resetn(i_resetn),
            .lo(lo.dst),
            .i_code(code_r[g]),
            .i_enable(cw_en_r[g]),
            .o_lo_i(o_lo_i[g]),
            .o_lo_q(o_lo_q[g]),
            .o_fine_sel(o_fine_sel[2*g+1:2*g]),
            .o_enable(o_cw_enable[g])
        );
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    sequence s_release;
        sync_reset_s2_r ##1 !sync_reset_s2_r;
    endsequence

    chk_div_held_static: assert property ( // R15
        sync_reset_s2_r |=> (phase_r == PHASE_START))
        else $error("Divider moved while the sync reset was held.");
    chk_div_step_run: assert property ( // R7
        !sync_reset_s2_r |=> (phase_r == $past(phase_r) + PHASE_STEP))
        else $error("Divider did not advance one quarter per edge.");
    chk_pin_to_hold: assert property ( // R10
        i_lo_sync_reset |-> ##2 sync_reset_s2_r ##1 (phase_r == PHASE_START))
        else $error("Sync pin did not force the divider to its start.");
    chk_release_restart: assert property ( // R13
        s_release |-> (phase_r == PHASE_START) ##1 (phase_r == PHASE_STEP))
        else $error("Divider did not restart on the first edge.");
    chk_code_write_ch0: assert property ( // R3
        (wr_strobe && wr_addr == ADDR_CW_CHANNEL_PHASE_CONTROL &&
            chan_sel_r[0]) |=> (code_r[0] == $past(frame_word[CODE_MSB:0])))
        else $error("Phase code write did not reach channel zero.");
    chk_enable_write: assert property ( // R14
        (wr_strobe && wr_addr == ADDR_CW_CHANNEL_PHASE_CONTROL &&
            chan_sel_r[1]) |=> ##1 (o_cw_enable[1] ==
            $past(frame_word[CW_ENABLE_BIT], 2)))
        else $error("Enable bit did not reach channel one output.");
    chk_unselected_keep: assert property ( // R1
        (wr_strobe && !chan_sel_r[2]) |=> $stable(code_r[2]))
        else $error("Unselected channel code was changed.");
    chk_apply_boundary: assert property ( // R16
        (!sync_reset_s2_r && phase_r != PHASE_LAST) |-> !lo.apply)
        else $error("Codes applied away from the cycle boundary.");
endmodule

//--- verif/lo_sync_driver.sv
// Array LO sync pulse driver standing in front of the LO block.
`timescale 1ns/1ps
module lo_sync_driver (
    input wire logic i_clock,
    input wire logic i_start,
    input wire logic [3:0] i_hold,
    output logic o_lo_sync_reset
);
    logic [3:0] left_r = 4'h0;
    initial o_lo_sync_reset = 1'b0;
    // Both edges move on a falling 4x edge, leaving half a period of setup.
    always @(negedge i_clock) begin
        if (left_r != 4'h0) begin
            left_r <= left_r - 4'h1;
            if (left_r == 4'h1) begin
                o_lo_sync_reset <= 1'b0;
            end
        end else if (i_start && !o_lo_sync_reset) begin
            left_r <= i_hold;
            o_lo_sync_reset <= 1'b1;
        end
    end
endmodule

//--- verif/test_cw_quadrature_lo_phase_select.sv
// Self-checking bench for the CW quadrature LO phase select block.
`timescale 1ns/1ps
module test_cw_quadrature_lo_phase_select
    import cw_lo_pkg::*;
;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic csn = 1'b1;
    logic sclk = 1'b0;
    logic host_sdio = 1'b0;
    logic sync_req = 1'b0;
    logic [3:0] sync_len = 4'hC;
    logic sdio_out;
    logic sdio_oe;
    logic lo_sync;
    logic [7:0] lo_i;
    logic [7:0] lo_q;
    logic [15:0] fine;
    logic [7:0] cw_en;
    logic [7:0] en_v;
    logic [7:0] rd;
    logic [7:0] pi [4];
    logic [7:0] pq [4];
    logic [3:0] code_a [8];
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int lat [2];
    wire sdio_wire = sdio_oe ? sdio_out : host_sdio;

    cw_quadrature_lo_phase_select #(.CHANNELS(NUM_CHANNELS))
        cw_quadrature_lo_phase_select_i (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_lo_sync_reset(lo_sync),
        .i_spi_csn(csn), .i_spi_sclk(sclk), .i_spi_sdio(sdio_wire),
        .o_spi_sdio(sdio_out), .o_spi_sdio_oe(sdio_oe), .o_lo_i(lo_i),
        .o_lo_q(lo_q), .o_fine_sel(fine), .o_cw_enable(cw_en));

    lo_sync_driver lo_sync_driver_i (.i_clock(i_clock), .i_start(sync_req),
        .i_hold(sync_len), .o_lo_sync_reset(lo_sync));

    initial begin
        forever #20 i_clock = ~i_clock;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic tick(input int n = 1);
        repeat (n) begin
            @(posedge i_clock);
            #1;
        end
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                              input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // Six 4x cycles per half period keep the sampled serial clock legal.
    task automatic spi(input logic [23:0] frame);
        csn = 1'b0;
        rd = 8'h00;
        for (int b = 23; b >= 0; b--) begin
            host_sdio = frame[b];
            tick(6);
            if (b < 8) rd[b] = sdio_wire;
            if (b == 7 && frame[23]) check_byte({7'h0, sdio_oe}, 8'h01, "oe");
            sclk = 1'b1;
            tick(6);
            sclk = 1'b0;
        end
        csn = 1'b1;
        tick(6);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        spi({3'h0, a, d});
    endtask

    task automatic rdreg(input logic [12:0] a, input logic [7:0] e,
                         input string what);
        spi({3'h4, a, 8'h00});
        check_byte(rd, e, what);
    endtask

    task automatic sample_lo();
        for (int t = 0; t < 4; t++) begin
            tick();
            pi[t] = lo_i;
            pq[t] = lo_q;
        end
    endtask

    task automatic check_lead();
        logic [3:0] base;
        logic [7:0] got;
        logic [7:0] exp;
        int k;
        sample_lo();
        k = code_a[0][3:2];
        for (int t = 0; t < 4; t++) base[t] = pi[(t + 4 - k) % 4][0];
        got = {7'h0, base == 4'h3 || base == 4'h6 || base == 4'hC ||
               base == 4'h9};
        check_byte(got, 8'h01, "duty");
        for (int g = 0; g < 8; g++) begin
            k = code_a[g][3:2];
            for (int t = 0; t < 4; t++) begin
                got[t] = pi[t][g];
                got[t+4] = pq[t][g];
                exp[t] = base[(t + k) % 4];
                exp[t+4] = base[(t + k + 3) % 4];
            end
            check_byte(got, exp, "rotation");
            check_byte({6'h0, fine[2*g +: 2]}, {6'h0, code_a[g][1:0]},
                       "fine");
        end
    endtask

    task automatic program_pass(input logic [3:0] off);
        for (int g = 0; g < 8; g++) begin
            code_a[g] = off + 4'(g);
            en_v[g] = g[0] ^ off[3];
            wr(ADDR_CHANNEL_SELECT, 8'h01 << g);
            wr(ADDR_CW_CHANNEL_PHASE_CONTROL, {3'h0, en_v[g], code_a[g]});
        end
        tick(12);
        check_byte(cw_en, en_v, "enable");
        check_lead();
    endtask

    task automatic sync_pulse(input int pre, input int idx);
        logic [7:0] ei;
        logic [7:0] eq;
        tick(pre);
        sync_req = 1'b1;
        while (lo_sync !== 1'b1) tick();
        sync_req = 1'b0;
        tick(4);
        sample_lo();
        for (int g = 0; g < 8; g++) begin
            ei[g] = code_a[g][3:2] < 2'h2;
            eq[g] = code_a[g][3:2] == 2'h1 || code_a[g][3:2] == 2'h2;
        end
        for (int t = 0; t < 4; t++) begin
            check_byte(pi[t], ei, "held i");
            check_byte(pq[t], eq, "held q");
        end
        while (lo_sync !== 1'b0) tick();
        lat[idx] = 0;
        while (lo_i[0] === ei[0] && lat[idx] < 20) begin
            tick();
            lat[idx]++;
        end
    endtask

    initial begin
        tick(10);
        i_resetn = 1'b1;
        check_byte(cw_en, 8'h00, "reset enable");
        rdreg(ADDR_CHANNEL_SELECT, CHANNEL_SELECT_RESET, "select");
        rdreg(ADDR_CW_CHANNEL_PHASE_CONTROL, 8'h00, "ctrl");
        wr(ADDR_CW_CHANNEL_PHASE_CONTROL, 8'h15);
        tick(12);
        check_byte(cw_en, 8'hFF, "broadcast");
        check_byte(fine[15:8], 8'h55, "broadcast fine");
        program_pass(4'h0);
        program_pass(4'h8);
        wr(ADDR_CHANNEL_SELECT, 8'h06);
        rdreg(ADDR_CW_CHANNEL_PHASE_CONTROL, {3'h0, en_v[1], code_a[1]},
              "lowest");
        wr(13'h0007, 8'hAA);
        rdreg(13'h0007, 8'h00, "unmapped");
        wr(ADDR_CHANNEL_SELECT, 8'h00);
        rdreg(ADDR_CW_CHANNEL_PHASE_CONTROL, 8'h00, "none");
        sync_pulse(0, 0);
        sync_pulse(1, 1);
        check_byte(8'(lat[0]), 8'(lat[1]), "restart");
        check_byte({7'h0, lat[0] < 20}, 8'h01, "restart bound");
        check_lead();
        summarize();
    end
endmodule
